// [core/bfx_exec.sv]
// execution of bit clear and flag-conditioned relative branches
// assumes a fetch stage on i_clock that holds the opcode in Q1 and
// a data memory with one-clock registered read data
`timescale 1ns/1ps
module bfx_exec (
	// clock and reset
	input  wire logic                       i_clock,
	input  wire logic                       i_resetn,
	// fetch stage
	input  wire logic [bfx_pkg::OP_W-1:0]   i_opcode,
	input  wire logic                       i_opcode_valid,
	input  wire logic [bfx_pkg::PC_W-1:0]   i_pc_inc,
	// machine state
	input  wire logic                       i_ext_en,
	input  wire logic [bfx_pkg::BANK_W-1:0] i_bank_sel,
	input  wire logic [bfx_pkg::ADDR_W-1:0] i_idx_base,
	input  wire logic                       i_flag_neg,
	input  wire logic                       i_flag_carry,
	input  wire logic                       i_flag_ovfl,
	input  wire logic                       i_flag_zero,
	// data memory
	input  wire logic [bfx_pkg::DATA_W-1:0] i_rdata,
	output logic [bfx_pkg::ADDR_W-1:0]      o_addr,
	output logic                            o_rd_en,
	output logic                            o_wr_en,
	output logic [bfx_pkg::DATA_W-1:0]      o_wdata,
	output logic                            o_indexed,
	// program counter
	output logic                            o_pc_load,
	output logic [bfx_pkg::PC_W-1:0]        o_pc_target,
	// pipeline status
	output logic                            o_nop_cycle,
	output logic [1:0]                      o_phase
);
	// classify an opcode into an operation kind
	function automatic bfx_pkg::bfx_kind_t classify(input logic [bfx_pkg::OP_W-1:0] op);
		logic [7:0] hi;
		hi = op[bfx_pkg::OP_HI_LSB +: 8];
		if (op[bfx_pkg::OP_NIB_LSB +: 4] == bfx_pkg::PAT_BIT_CLEAR) begin
			classify = bfx_pkg::K_BITCLR;
		end else begin
			case (hi)
				bfx_pkg::PAT_BR_NEG:      classify = bfx_pkg::K_BR_N;
				bfx_pkg::PAT_BR_NO_CARRY: classify = bfx_pkg::K_BR_NC;
				bfx_pkg::PAT_BR_NON_NEG:  classify = bfx_pkg::K_BR_NN;
				bfx_pkg::PAT_BR_NO_OVFL:  classify = bfx_pkg::K_BR_NOV;
				bfx_pkg::PAT_BR_NONZERO:  classify = bfx_pkg::K_BR_NZ;
				default:                  classify = bfx_pkg::K_NONE;
			endcase
		end
	endfunction

	// branch condition for a kind against the flags
	function automatic logic cond_met(input bfx_pkg::bfx_kind_t k, input logic n, input logic c,
		input logic v, input logic z);
		case (k)
			bfx_pkg::K_BR_N:   cond_met = n;
			bfx_pkg::K_BR_NC:  cond_met = !c;
			bfx_pkg::K_BR_NN:  cond_met = !n;
			bfx_pkg::K_BR_NOV: cond_met = !v;
			bfx_pkg::K_BR_NZ:  cond_met = !z;
			default:           cond_met = 1'b0;
		endcase
	endfunction

	// phase source
	logic [1:0] phase;
	bfx_phase_gen u_phase (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.o_phase  (phase)
	);

	// operand address resolution
	bfx_addr_if ai ();
	bfx_addr_resolve u_addr (
		.a (ai)
	);

	// state
	bfx_pkg::bfx_state_t           state_r, state_nxt;
	bfx_pkg::bfx_kind_t            kind_r, kind_nxt;
	logic [bfx_pkg::OP_W-1:0]      op_r, op_nxt;
	logic                          taken_r, taken_nxt;
	logic [bfx_pkg::ADDR_W-1:0]    addr_r, addr_nxt;
	logic                          rd_en_r, rd_en_nxt;
	logic                          wr_en_r, wr_en_nxt;
	logic [bfx_pkg::DATA_W-1:0]    wdata_r, wdata_nxt;
	logic                          indexed_r, indexed_nxt;
	logic                          pc_load_r, pc_load_nxt;
	logic [bfx_pkg::PC_W-1:0]      target_r, target_nxt;
	logic                          nop_r, nop_nxt;
	logic [1:0]                    phase_r;

	// operand fields come straight from fetch during decode
	logic [bfx_pkg::OP_W-1:0]      op_cur;
	logic [2:0]                    bit_pos;
	logic [bfx_pkg::DATA_W-1:0]    clr_mask;
	logic [bfx_pkg::PC_W-1:0]      offset_x2;

	always_comb begin
		op_cur       = (phase == bfx_pkg::Q1) ? i_opcode : op_r;
		ai.file_addr = op_cur[7:0];
		ai.acc_bit   = op_cur[bfx_pkg::ACC_BIT_POS];
		ai.ext_en    = i_ext_en;
		ai.bank      = i_bank_sel;
		ai.idx_base  = i_idx_base;
		bit_pos      = op_r[bfx_pkg::BITPOS_LSB +: 3];
		clr_mask     = ~(8'h01 << bit_pos);
		// sign extend then double; the 8-bit offset spans -256..+254 bytes
		offset_x2    = {{(bfx_pkg::PC_W-9){op_r[7]}}, op_r[7:0], 1'b0};
	end

	// sequencing of one instruction cycle; flags are only read, never driven
	always_comb begin
		state_nxt   = state_r;
		kind_nxt    = kind_r;
		op_nxt      = op_r;
		taken_nxt   = taken_r;
		addr_nxt    = addr_r;
		rd_en_nxt   = 1'b0;
		wr_en_nxt   = 1'b0;
		wdata_nxt   = wdata_r;
		indexed_nxt = indexed_r;
		pc_load_nxt = 1'b0;
		target_nxt  = target_r;
		nop_nxt     = nop_r;
		case (state_r)
			bfx_pkg::ST_EXEC: begin
				case (phase)
					bfx_pkg::Q1: begin
						// decode; a bit clear starts its read now
						taken_nxt = 1'b0;
						if (i_opcode_valid) begin
							op_nxt   = i_opcode;
							kind_nxt = classify(i_opcode);
							if (classify(i_opcode) == bfx_pkg::K_BITCLR) begin
								rd_en_nxt   = 1'b1;
								addr_nxt    = ai.data_addr;
								indexed_nxt = ai.indexed;
							end
						end else begin
							kind_nxt = bfx_pkg::K_NONE;
						end
					end
					bfx_pkg::Q2: begin
						// read data lands at the next edge
					end
					bfx_pkg::Q3: begin
						if (kind_r == bfx_pkg::K_BITCLR) begin
							wdata_nxt = i_rdata & clr_mask;
							wr_en_nxt = 1'b1;
						end else if (cond_met(kind_r, i_flag_neg, i_flag_carry, i_flag_ovfl, i_flag_zero)) begin
							// pc is already past the branch word
							target_nxt  = i_pc_inc + offset_x2;
							pc_load_nxt = 1'b1;
							taken_nxt   = 1'b1;
						end
					end
					bfx_pkg::Q4: begin
						if (taken_r) begin
							state_nxt = bfx_pkg::ST_NOP;
							nop_nxt   = 1'b1;
						end
					end
					default: begin
						state_nxt = bfx_pkg::ST_EXEC;
					end
				endcase
			end
			bfx_pkg::ST_NOP: begin
				// the fetched word is discarded for all four phases
				if (phase == bfx_pkg::Q4) begin
					state_nxt = bfx_pkg::ST_EXEC;
					nop_nxt   = 1'b0;
					kind_nxt  = bfx_pkg::K_NONE;
				end
			end
			default: begin
				state_nxt = bfx_pkg::ST_EXEC;
				nop_nxt   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state_r   <= bfx_pkg::ST_EXEC;
			kind_r    <= bfx_pkg::K_NONE;
			op_r      <= 16'h0000;
			taken_r   <= 1'b0;
			addr_r    <= 12'h000;
			rd_en_r   <= 1'b0;
			wr_en_r   <= 1'b0;
			wdata_r   <= 8'h00;
			indexed_r <= 1'b0;
			pc_load_r <= 1'b0;
			target_r  <= 21'h000000;
			nop_r     <= 1'b0;
			phase_r   <= bfx_pkg::Q1;
		end else begin
			state_r   <= state_nxt;
			kind_r    <= kind_nxt;
			op_r      <= op_nxt;
			taken_r   <= taken_nxt;
			addr_r    <= addr_nxt;
			rd_en_r   <= rd_en_nxt;
			wr_en_r   <= wr_en_nxt;
			wdata_r   <= wdata_nxt;
			indexed_r <= indexed_nxt;
			pc_load_r <= pc_load_nxt;
			target_r  <= target_nxt;
			nop_r     <= nop_nxt;
			phase_r   <= phase;
		end
	end

	// outputs straight from flops
	assign o_addr      = addr_r;
	assign o_rd_en     = rd_en_r;
	assign o_wr_en     = wr_en_r;
	assign o_wdata     = wdata_r;
	assign o_indexed   = indexed_r;
	assign o_pc_load   = pc_load_r;
	assign o_pc_target = target_r;
	assign o_nop_cycle = nop_r;
	assign o_phase     = phase_r; // lags the internal phase by one clock
endmodule

// [core/bfx_pkg.sv]
// constants for the bit-clear and flag-branch execution block
// assumes a four-phase instruction cycle of four i_clock periods
package bfx_pkg;

	// instruction cycle phases, one clock each
	localparam logic [1:0] Q1 = 2'h0;
	localparam logic [1:0] Q2 = 2'h1;
	localparam logic [1:0] Q3 = 2'h2;
	localparam logic [1:0] Q4 = 2'h3;

	// widths
	localparam int OP_W   = 16;
	localparam int PC_W   = 21;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int BANK_W = 4;

	// opcode field positions
	localparam int OP_HI_LSB   = 8;
	localparam int OP_NIB_LSB  = 12;
	localparam int BITPOS_LSB  = 9;
	localparam int ACC_BIT_POS = 8;

	// opcode patterns
	localparam logic [3:0] PAT_BIT_CLEAR     = 4'h9;
	localparam logic [7:0] PAT_BR_NEG        = 8'he6;
	localparam logic [7:0] PAT_BR_NO_CARRY   = 8'he3;
	localparam logic [7:0] PAT_BR_NON_NEG    = 8'he7; // to be confirmed, see note
	localparam logic [7:0] PAT_BR_NO_OVFL    = 8'he5;
	localparam logic [7:0] PAT_BR_NONZERO    = 8'he1;

	// addressing: low access range and indexed range end at this file address
	localparam logic [7:0]  ACC_LOW_MAX   = 8'h5f;
	localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;
	localparam logic [3:0]  ACC_HIGH_BANK = 4'hf;

	// decoded operation kinds
	typedef enum logic [2:0] {
		K_NONE    = 3'h0,
		K_BITCLR  = 3'h1,
		K_BR_N    = 3'h2,
		K_BR_NC   = 3'h3,
		K_BR_NN   = 3'h4,
		K_BR_NOV  = 3'h5,
		K_BR_NZ   = 3'h6
	} bfx_kind_t;

	// instruction cycle state
	typedef enum logic [0:0] {
		ST_EXEC = 1'h0,
		ST_NOP  = 1'h1
	} bfx_state_t;

endpackage

// [core/bfx_addr_if.sv]
// carries a file-register operand to the address resolver and back
// assumes both ends run combinationally within the same clock
`timescale 1ns/1ps
interface bfx_addr_if;
	logic [7:0]                  file_addr;
	logic                        acc_bit;
	logic                        ext_en;
	logic [bfx_pkg::BANK_W-1:0]  bank;
	logic [bfx_pkg::ADDR_W-1:0]  idx_base;
	logic [bfx_pkg::ADDR_W-1:0]  data_addr;
	logic                        indexed;

	modport requester (output file_addr, acc_bit, ext_en, bank, idx_base, input data_addr, indexed);
	modport resolver  (input file_addr, acc_bit, ext_en, bank, idx_base, output data_addr, indexed);
endinterface

// [core/bfx_phase_gen.sv]
// four-phase instruction cycle counter
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module bfx_phase_gen (
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_resetn,
	// current phase
	output logic [1:0]      o_phase
);
	logic [1:0] phase_r;
	logic [1:0] phase_nxt;

	// wraps Q4 back to Q1
	always_comb begin
		phase_nxt = phase_r + 2'h1;
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			phase_r <= bfx_pkg::Q1;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	assign o_phase = phase_r;
endmodule

// [core/bfx_addr_resolve.sv]
// maps an 8-bit file operand to a 12-bit data-memory address
// assumes bank select and the index base are stable during decode
`timescale 1ns/1ps
module bfx_addr_resolve (
	// operand in, address out
	bfx_addr_if.resolver   a
);
	// bank-select path, indexed path, or access bank split
	always_comb begin
		a.indexed   = 1'b0;
		a.data_addr = {a.bank, a.file_addr};
		if (a.acc_bit == 1'b0) begin
			if (a.ext_en && (a.file_addr <= bfx_pkg::ACC_LOW_MAX)) begin
				a.indexed   = 1'b1;
				a.data_addr = a.idx_base + {4'h0, a.file_addr};
			end else if (a.file_addr <= bfx_pkg::ACC_LOW_MAX) begin
				a.data_addr = {bfx_pkg::ACC_LOW_BANK, a.file_addr};
			end else begin
				a.data_addr = {bfx_pkg::ACC_HIGH_BANK, a.file_addr};
			end
		end
	end
endmodule

// [verification/bfx_exec_chk.sv]
// port assertions for the execution block
// assumes the bench holds the opcode for a whole instruction cycle
`timescale 1ns/1ps
module bfx_exec_chk (
	// clock and reset
	input wire logic                       i_clock,
	input wire logic                       i_resetn,
	// inputs watched
	input wire logic [bfx_pkg::OP_W-1:0]   i_opcode,
	input wire logic [bfx_pkg::PC_W-1:0]   i_pc_inc,
	input wire logic                       i_ext_en,
	input wire logic [bfx_pkg::BANK_W-1:0] i_bank_sel,
	input wire logic [bfx_pkg::ADDR_W-1:0] i_idx_base,
	input wire logic                       i_flag_neg,
	input wire logic                       i_flag_carry,
	input wire logic                       i_flag_ovfl,
	input wire logic                       i_flag_zero,
	input wire logic [bfx_pkg::DATA_W-1:0] i_rdata,
	// outputs watched
	input wire logic [bfx_pkg::ADDR_W-1:0] o_addr,
	input wire logic                       o_rd_en,
	input wire logic                       o_wr_en,
	input wire logic [bfx_pkg::DATA_W-1:0] o_wdata,
	input wire logic                       o_indexed,
	input wire logic                       o_pc_load,
	input wire logic [bfx_pkg::PC_W-1:0]   o_pc_target,
	input wire logic                       o_nop_cycle
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	// read, modify, write spacing and data
	rd_to_wr_a: assert property (o_rd_en |-> ##2 o_wr_en)
		else $error("write missing");
	wdata_clr_a: assert property (o_wr_en |-> o_wdata == ($past(i_rdata) & ~(8'h01 << $past(i_opcode[11:9], 3))))
		else $error("bad cleared data");
	// operand address forms
	bank_addr_a: assert property (o_rd_en && $past(i_opcode[8]) |-> o_addr == {$past(i_bank_sel), $past(i_opcode[7:0])})
		else $error("bad banked address");
	idx_addr_a: assert property (o_rd_en && !$past(i_opcode[8]) && $past(i_ext_en) && $past(i_opcode[7:0]) <= 8'h5f
		|-> o_indexed && o_addr == $past(i_idx_base) + $past(i_opcode[7:0]))
		else $error("bad indexed address");
	// a load only under its flag condition
	br_cond_a: assert property (o_pc_load |-> $past(i_opcode[15:8]) == bfx_pkg::PAT_BR_NEG && $past(i_flag_neg)
		|| $past(i_opcode[15:8]) == bfx_pkg::PAT_BR_NO_CARRY && !$past(i_flag_carry)
		|| $past(i_opcode[15:8]) == bfx_pkg::PAT_BR_NON_NEG && !$past(i_flag_neg)
		|| $past(i_opcode[15:8]) == bfx_pkg::PAT_BR_NO_OVFL && !$past(i_flag_ovfl)
		|| $past(i_opcode[15:8]) == bfx_pkg::PAT_BR_NONZERO && !$past(i_flag_zero))
		else $error("load without condition");
	br_target_a: assert property (o_pc_load |-> o_pc_target == $past(i_pc_inc) + {{12{$past(i_opcode[7])}}, $past(i_opcode[7:0]), 1'b0})
		else $error("bad branch target");
	// taken branch costs exactly one discarded cycle
	nop_len_a: assert property (o_pc_load |=> o_nop_cycle [*4] ##1 !o_nop_cycle)
		else $error("bad nop length");
	nop_quiet_a: assert property (o_nop_cycle |-> !o_rd_en && !o_wr_en && !o_pc_load)
		else $error("activity in nop");
endmodule

bind bfx_exec bfx_exec_chk i_bfx_exec_chk (.i_clock, .i_resetn, .i_opcode, .i_pc_inc, .i_ext_en, .i_bank_sel,
	.i_idx_base, .i_flag_neg, .i_flag_carry, .i_flag_ovfl, .i_flag_zero, .i_rdata, .o_addr, .o_rd_en,
	.o_wr_en, .o_wdata, .o_indexed, .o_pc_load, .o_pc_target, .o_nop_cycle);

// [verification/bfx_dmem_model.sv]
// data memory model, one-clock registered read
// assumes one-clock request pulses from the block
`timescale 1ns/1ps
module bfx_dmem_model (
	// clock
	input  wire logic                       i_clock,
	// request
	input  wire logic [bfx_pkg::ADDR_W-1:0] i_addr,
	input  wire logic                       i_rd_en,
	input  wire logic                       i_wr_en,
	input  wire logic [bfx_pkg::DATA_W-1:0] i_wdata,
	// read data
	output logic      [bfx_pkg::DATA_W-1:0] o_rdata
);
	logic [7:0] mem [4096];

	// fill pattern shared with the bench copy
	initial begin
		for (int k = 0; k < 4096; k++) begin
			mem[k] = k[7:0] ^ 8'ha5;
		end
		o_rdata = 8'h00;
	end

	// data toggles outside a read so stale bytes never pass
	always @(posedge i_clock) begin
		o_rdata <= i_rd_en ? mem[i_addr] : ~o_rdata;
		if (i_wr_en) begin
			mem[i_addr] <= i_wdata;
		end
	end
endmodule

// [verification/bfx_exec_tb.sv]
// self-checking bench for the execution block
// assumes the data memory model and the bound checker
`timescale 1ns/1ps
module testbench;
	logic                       i_clock = 1'b0;
	logic                       i_resetn = 1'b0;
	logic [15:0]                i_opcode = 16'h0000;
	logic                       i_opcode_valid = 1'b0;
	logic [20:0]                i_pc_inc = 21'h000000;
	logic                       i_ext_en = 1'b0;
	logic [3:0]                 i_bank_sel = 4'h0;
	logic [11:0]                i_idx_base = 12'h000;
	logic                       i_flag_neg = 1'b0;
	logic                       i_flag_carry = 1'b0;
	logic                       i_flag_ovfl = 1'b0;
	logic                       i_flag_zero = 1'b0;
	logic [7:0]                 i_rdata;
	logic [11:0]                o_addr;
	logic                       o_rd_en, o_wr_en, o_indexed, o_pc_load, o_nop_cycle;
	logic [7:0]                 o_wdata;
	logic [20:0]                o_pc_target;
	logic [1:0]                 o_phase;
	logic [7:0]                 ref_mem [4096];
	logic [7:0]                 kinds [8] = '{8'he6, 8'he3, 8'he7, 8'he5, 8'he1, 8'h90, 8'h90, 8'hd0};
	logic [15:0]                rnd = 16'h519a;
	logic [7:0]                 hi;
	int                         bad_count = 0;
	int                         num_checks = 0;

	bfx_exec i_bfx_exec (.i_clock, .i_resetn, .i_opcode, .i_opcode_valid, .i_pc_inc, .i_ext_en, .i_bank_sel,
		.i_idx_base, .i_flag_neg, .i_flag_carry, .i_flag_ovfl, .i_flag_zero, .i_rdata, .o_addr, .o_rd_en,
		.o_wr_en, .o_wdata, .o_indexed, .o_pc_load, .o_pc_target, .o_nop_cycle, .o_phase);
	bfx_dmem_model i_bfx_dmem_model (.i_clock, .i_addr(o_addr), .i_rd_en(o_rd_en), .i_wr_en(o_wr_en),
		.i_wdata(o_wdata), .o_rdata(i_rdata));

	always #25 i_clock = ~i_clock;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one instruction from its Q1 edge to the next free Q1 slot, branch target reference built from integers
	task automatic run_op(input logic [15:0] op, input logic vld);
		logic [7:0]  f;
		logic [11:0] a;
		logic        idx, clr, tk;
		int          tgt;
		f = op[7:0];
		clr = vld && op[15:12] == 4'h9;
		idx = !op[8] && i_ext_en && f <= 8'h5f;
		a = op[8] ? {i_bank_sel, f} : idx ? i_idx_base + f : {(f <= 8'h5f) ? 4'h0 : 4'hf, f};
		tk = vld && (op[15:8] == 8'he6 && i_flag_neg || op[15:8] == 8'he3 && !i_flag_carry
			|| op[15:8] == 8'he7 && !i_flag_neg || op[15:8] == 8'he5 && !i_flag_ovfl
			|| op[15:8] == 8'he1 && !i_flag_zero);
		tgt = (int'(i_pc_inc) + 2 * int'($signed(f))) & 32'h1fffff;
		i_opcode = op;
		i_opcode_valid = vld;
		// read pulse stands only in the clock after the decode edge
		@(negedge i_clock);
		check(o_phase, 2'h0);
		check(o_rd_en, clr);
		if (clr) begin
			check(o_addr, a);
			check(o_indexed, idx);
		end
		repeat (2) @(negedge i_clock);
		check(o_wr_en, clr);
		check(o_pc_load, tk);
		if (clr) begin
			check(o_wdata, ref_mem[a] & ~(8'h01 << op[11:9]));
			ref_mem[a] = ref_mem[a] & ~(8'h01 << op[11:9]);
		end
		if (tk) begin
			check(o_pc_target, tgt);
			@(negedge i_clock);
			// a bit clear offered in the discarded cycle must be dropped
			i_opcode = {4'h9, op[11:0]};
			repeat (3) @(negedge i_clock);
			check(o_nop_cycle, 1'b1);
			@(negedge i_clock);
			check(o_nop_cycle, 1'b0);
			check(o_rd_en, 1'b0);
		end else begin
			check(o_nop_cycle, 1'b0);
			// wait out the fourth phase so the next word meets a decode edge
			@(negedge i_clock);
		end
	endtask

	// random mix of all kinds, field boundaries and invalid slots
	initial begin
		for (int k = 0; k < 4096; k++) begin
			ref_mem[k] = k[7:0] ^ 8'ha5;
		end
		repeat (16) @(negedge i_clock);
		i_resetn = 1'b1;
		for (int t = 0; t < 150; t++) begin
			rnd = lfsr(rnd);
			i_bank_sel = rnd[3:0];
			i_idx_base = {rnd[15:12], rnd[7:0]};
			{i_flag_neg, i_flag_carry, i_flag_ovfl, i_flag_zero} = rnd[7:4];
			i_ext_en = rnd[8];
			rnd = lfsr(rnd);
			i_pc_inc = {rnd[4:0], rnd};
			rnd = lfsr(rnd);
			hi = kinds[rnd[2:0]];
			if (hi[7:4] == 4'h9) begin
				hi[3:0] = rnd[6:3];
			end
			run_op({hi, rnd[11] ? 8'h5f + rnd[12] : rnd[15:8]}, rnd[10:9] != 2'h0);
		end
		close_out();
	end

	// watchdog well past 150 ops of at most 8 clocks
	initial begin
		#(3000 * 50);
		bad_count++;
		close_out();
	end
endmodule
